// ### core/dsr_defines.svh
// Notes on behaviour
// [R1] command 1xh seeks heads to cylinder zero
// [R2] failed seek sets track-zero error, status error
// [R3] disable command takes one sector before check
// [R4] matching password turns lock function off
// [R5] disable leaves stored master password intact
// [R6] host should disable only when unlocked
// [R7] disable sector: word0 bit0 selector, words1-16 password
// [R8] selector zero checks user, one checks master
// [R9] host sends prepare right before erase
// [R10] host sends prepare right before format
// [R11] prepare completes with no data phase
// [R12] erase without prior prepare is aborted
// [R13] erase covers block zero to physical last
// [R14] erase takes sector, aborts on mismatch
// [R15] erase word0: bit0 selector, bit1 mode; the device never reads bit1
// [R16] erase writes zeros, no verify, lists untouched
// [R17] erase success disables lock, keeps master
// [R18] lock off: erase skips password compare
// [R19] erase duration reported in identify word 89
// [R20] frozen mode rejects disable and erase
// [R21] sector data moves one 16-bit word per access
// [R22] abort sets aborted flag, error, busy clear
// [R23] any other command clears pending prepare
`ifndef DSR_DEFINES_SVH
`define DSR_DEFINES_SVH
`define DSR_CMD_RECAL_HI   4'h1
`define DSR_CMD_DISABLE    8'hf6
`define DSR_CMD_PREPARE    8'hf3
`define DSR_CMD_ERASE      8'hf4
`define DSR_CMD_FORMAT     8'hf7
`define DSR_SECTOR_WORDS   9'h100
`define DSR_PW_FIRST       9'h001
`define DSR_PW_LAST        9'h010
`define DSR_ERR_TRACK0_BIT 1
`define DSR_ERR_ABORT_BIT  2
`define DSR_ST_BSY_BIT     7
`define DSR_ST_RDY_BIT     6
`define DSR_ST_DSC_BIT     4
`define DSR_ST_DRQ_BIT     3
`define DSR_ST_ERR_BIT     0
`define DSR_CTL_SEL_BIT    0
`define DSR_CTL_MODE_BIT   1
`define DSR_ID_ERASE_WORD  8'h59
`define DSR_ERASE_MINUTES  16'h0001
`define DSR_LBA_W          28
`endif

// ### core/dsr_pkg.sv
package dsr_pkg;
    typedef enum logic [2:0] {
        DSR_IDLE  = 3'b000,
        DSR_DATA  = 3'b001,
        DSR_CHECK = 3'b011,
        DSR_SEEK  = 3'b010,
        DSR_WIPE  = 3'b110,
        DSR_DONE  = 3'b111
    } dsr_state_e;
    typedef logic [15:0] dsr_word_t;
endpackage : dsr_pkg

// ### core/dsr_if.sv
`timescale 1ns/1ps
// task-file link: command/head writes, status/error reads, 16-bit data port
interface dsr_if;
    logic [7:0]  command_code;
    logic        cmd_wr;
    logic [7:0]  drive_head_select;
    logic [15:0] data_wr;
    logic        data_wr_stb;
    logic [7:0]  command_status;
    logic [7:0]  error_flags;
    modport dev  (input command_code, cmd_wr, drive_head_select, data_wr, data_wr_stb,
                  output command_status, error_flags);
    modport host (output command_code, cmd_wr, drive_head_select, data_wr, data_wr_stb,
                  input command_status, error_flags);
endinterface : dsr_if

// ### core/dsr_device.sv
`timescale 1ns/1ps
`include "dsr_defines.svh"
module dsr_device
    import dsr_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 clk_en,
    dsr_if.dev                        tf,
    input  wire logic                 frozen,
    input  wire logic                 seek_done,
    input  wire logic                 seek_fail,
    input  wire logic [`DSR_LBA_W-1:0] physical_last_block,
    input  wire logic                 wipe_ack,
    input  wire logic [8:0]           id_word_addr,
    output logic                      seek_start,
    output logic                      wipe_we,
    output logic [`DSR_LBA_W-1:0]     wipe_lba,
    output logic                      lock_enabled,
    output logic [15:0]               id_word_data
);
    dsr_state_e          state;
    logic [7:0]          cur_cmd;
    logic                prepared;
    logic [8:0]          word_cnt;
    logic                sel_master;
    logic                pw_match;
    logic [15:0]         user_pw   [1:16];
    logic [15:0]         master_pw [1:16];
    logic [7:0]          error_flags;
    logic [7:0]          status;

    function automatic logic [7:0] dsr_status(input logic busy, input logic drq, input logic err);
        dsr_status = 8'h00;
        dsr_status[`DSR_ST_BSY_BIT] = busy;
        dsr_status[`DSR_ST_RDY_BIT] = ~busy;
        dsr_status[`DSR_ST_DSC_BIT] = ~busy;
        dsr_status[`DSR_ST_DRQ_BIT] = drq;
        dsr_status[`DSR_ST_ERR_BIT] = err;
    endfunction : dsr_status

    assign tf.command_status = status;
    assign tf.error_flags    = error_flags;

    // stored passwords; only cleared to zero by reset, nothing in the project writes them
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            for (int i = 1; i <= 16; i++)
            begin
                user_pw[i]   <= 16'h0000;
                master_pw[i] <= 16'h0000;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state        <= DSR_IDLE;
            cur_cmd      <= 8'h00;
            prepared     <= 1'b0;
            word_cnt     <= 9'h000;
            sel_master   <= 1'b0;
            pw_match     <= 1'b1;
            error_flags  <= 8'h00;
            status       <= dsr_status(1'b0, 1'b0, 1'b0);
            seek_start   <= 1'b0;
            wipe_we      <= 1'b0;
            wipe_lba     <= '0;
            lock_enabled <= 1'b0;
        end
        else if (clk_en)
        begin
            seek_start <= 1'b0;
            case (state)
                DSR_IDLE:
                begin
                    if (tf.cmd_wr)
                    begin
                        cur_cmd     <= tf.command_code;
                        error_flags <= 8'h00;
                        prepared    <= (tf.command_code == `DSR_CMD_PREPARE); // see [R23]
                        if (tf.command_code[7:4] == `DSR_CMD_RECAL_HI)
                        begin
                            seek_start <= 1'b1; // see [R1]
                            status     <= dsr_status(1'b1, 1'b0, 1'b0);
                            state      <= DSR_SEEK;
                        end
                        else if (tf.command_code == `DSR_CMD_PREPARE)
                            status <= dsr_status(1'b0, 1'b0, 1'b0); // see [R11]
                        else if ((tf.command_code == `DSR_CMD_DISABLE || tf.command_code == `DSR_CMD_ERASE)
                                 && frozen)
                        begin
                            error_flags[`DSR_ERR_ABORT_BIT] <= 1'b1; // see [R20] see [R22]
                            status <= dsr_status(1'b0, 1'b0, 1'b1);
                        end
                        else if (tf.command_code == `DSR_CMD_ERASE && !prepared)
                        begin
                            error_flags[`DSR_ERR_ABORT_BIT] <= 1'b1; // see [R12] see [R22]
                            status <= dsr_status(1'b0, 1'b0, 1'b1);
                        end
                        else if (tf.command_code == `DSR_CMD_DISABLE || tf.command_code == `DSR_CMD_ERASE)
                        begin
                            word_cnt <= 9'h000;
                            pw_match <= 1'b1;
                            status   <= dsr_status(1'b0, 1'b1, 1'b0); // see [R3]
                            state    <= DSR_DATA;
                        end
                        else
                        begin
                            error_flags[`DSR_ERR_ABORT_BIT] <= 1'b1; // see [R22]
                            status <= dsr_status(1'b0, 1'b0, 1'b1);
                        end
                    end
                end
                DSR_DATA:
                begin
                    if (tf.data_wr_stb) // see [R21]
                    begin
                        if (word_cnt == 9'h000)
                            sel_master <= tf.data_wr[`DSR_CTL_SEL_BIT]; // see [R7] see [R15]
                        else if (word_cnt <= `DSR_PW_LAST)
                        begin
                            // see [R8]
                            if (tf.data_wr != (sel_master ? master_pw[word_cnt[4:0]] : user_pw[word_cnt[4:0]]))
                                pw_match <= 1'b0;
                        end
                        word_cnt <= word_cnt + 9'h001;
                        if (word_cnt == `DSR_SECTOR_WORDS - 9'h001)
                        begin
                            status <= dsr_status(1'b1, 1'b0, 1'b0);
                            state  <= DSR_CHECK;
                        end
                    end
                end
                DSR_CHECK:
                begin
                    // see [R18] unlocked erase ignores the compare
                    if (!pw_match && !(cur_cmd == `DSR_CMD_ERASE && !lock_enabled))
                    begin
                        error_flags[`DSR_ERR_ABORT_BIT] <= 1'b1; // see [R14] see [R22]
                        status <= dsr_status(1'b0, 1'b0, 1'b1);
                        state  <= DSR_IDLE;
                    end
                    else if (cur_cmd == `DSR_CMD_ERASE)
                    begin
                        wipe_lba <= '0; // see [R13]
                        wipe_we  <= 1'b1;
                        state    <= DSR_WIPE;
                    end
                    else
                    begin
                        lock_enabled <= 1'b0; // see [R4] see [R5]
                        status <= dsr_status(1'b0, 1'b0, 1'b0);
                        state  <= DSR_DONE;
                    end
                end
                DSR_SEEK:
                begin
                    if (seek_fail)
                    begin
                        error_flags[`DSR_ERR_TRACK0_BIT] <= 1'b1; // see [R2]
                        status <= dsr_status(1'b0, 1'b0, 1'b1);
                        state  <= DSR_IDLE;
                    end
                    else if (seek_done)
                    begin
                        status <= dsr_status(1'b0, 1'b0, 1'b0);
                        state  <= DSR_IDLE;
                    end
                end
                DSR_WIPE:
                begin
                    // zeros only, no read-back, defect lists untouched
                    if (wipe_ack) // see [R16]
                    begin
                        if (wipe_lba == physical_last_block) // see [R13]
                        begin
                            wipe_we      <= 1'b0;
                            lock_enabled <= 1'b0; // see [R17]
                            status <= dsr_status(1'b0, 1'b0, 1'b0);
                            state  <= DSR_DONE;
                        end
                        else
                            wipe_lba <= wipe_lba + `DSR_LBA_W'(1);
                    end
                end
                DSR_DONE:
                    state <= DSR_IDLE;
                default:
                    state <= DSR_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            id_word_data <= 16'h0000;
        else if (clk_en)
            id_word_data <= (id_word_addr == {1'b0, `DSR_ID_ERASE_WORD}) ? `DSR_ERASE_MINUTES : 16'h0000; // see [R19]
    end
endmodule : dsr_device

// ### core/dsr_host.sv
`timescale 1ns/1ps
`include "dsr_defines.svh"
module dsr_host
    import dsr_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    dsr_if.host              tf,
    input  wire logic        go,
    input  wire logic [7:0]  cmd,
    input  wire logic        sel_master,
    input  wire logic [15:0] pw_word,
    output logic [8:0]       pw_index,
    output logic             busy,
    output logic             done,
    output logic [7:0]       last_status,
    output logic [7:0]       last_error
);
    logic [8:0] cnt;
    logic       sending;
    // status trails the device by two edges through the flops below
    logic [1:0] wait_cnt;
    // device status passes across pins: two flops first
    logic [7:0] st_s1;
    logic [7:0] st_s2;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st_s1 <= 8'h00;
            st_s2 <= 8'h00;
        end
        else if (clk_en)
        begin
            st_s1 <= tf.command_status;
            st_s2 <= st_s1;
        end
    end

    assign tf.drive_head_select = 8'ha0;
    assign pw_index = cnt;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            tf.cmd_wr       <= 1'b0;
            tf.command_code <= 8'h00;
            tf.data_wr      <= 16'h0000;
            tf.data_wr_stb  <= 1'b0;
            cnt <= 9'h000;
            sending <= 1'b0;
            wait_cnt <= 2'h0;
            busy <= 1'b0;
            done <= 1'b0;
            last_status <= 8'h00;
            last_error  <= 8'h00;
        end
        else if (clk_en)
        begin
            tf.cmd_wr      <= 1'b0;
            tf.data_wr_stb <= 1'b0;
            done <= 1'b0;
            if (go && !busy)
            begin
                // prepare must be sent by software directly before erase/format; see [R9] see [R10]
                // disable is left to software to send only while unlocked; see [R6]
                tf.command_code <= cmd;
                tf.cmd_wr <= 1'b1;
                busy <= 1'b1;
                wait_cnt <= 2'h3;
                cnt <= 9'h000;
            end
            else if (wait_cnt != 2'h0)
                wait_cnt <= wait_cnt - 2'h1;
            else if (busy && !sending && st_s2[`DSR_ST_DRQ_BIT])
                sending <= 1'b1; // see [R3]
            else if (sending)
            begin
                tf.data_wr_stb <= 1'b1; // see [R21]
                // see [R7] see [R15] normal erase mode only
                tf.data_wr <= (cnt == 9'h000) ? {15'h0000, sel_master}
                            : (cnt <= `DSR_PW_LAST) ? pw_word : 16'h0000;
                cnt <= cnt + 9'h001;
                if (cnt == `DSR_SECTOR_WORDS - 9'h001)
                begin
                    // stale data request still in the flops; do not restart the sector
                    sending  <= 1'b0;
                    wait_cnt <= 2'h3;
                end
            end
            else if (busy && !st_s2[`DSR_ST_BSY_BIT] && !st_s2[`DSR_ST_DRQ_BIT])
            begin
                busy <= 1'b0;
                done <= 1'b1;
                last_status <= st_s2;
                last_error  <= tf.error_flags;
            end
        end
    end
endmodule : dsr_host

// ### tb/dsr_properties.sv
`timescale 1ns/1ps
module dsr_properties
(
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  command_code,
    input wire logic        cmd_wr,
    input wire logic [7:0]  drive_head_select,
    input wire logic [15:0] data_wr,
    input wire logic        data_wr_stb,
    input wire logic [7:0]  command_status,
    input wire logic [7:0]  error_flags
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    logic [7:0] last_cmd;
    logic [8:0] word_cnt;
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            last_cmd <= 8'h00;
        else if (cmd_wr)
            last_cmd <= command_code;
    end
    // counts sector words since the last command
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || cmd_wr)
            word_cnt <= 9'h000;
        else if (data_wr_stb)
            word_cnt <= word_cnt + 9'h001;
    end
    recal_track_zero_a: assert property ($rose(error_flags[1]) |-> last_cmd[7:4] == 4'h1 && command_status[0])
        else $error("track zero flag without head return");
    abort_status_a: assert property ($rose(error_flags[2]) |-> command_status[0] && !command_status[7])
        else $error("abort without error status");
    disable_request_a: assert property (cmd_wr && command_code == 8'hf6 |-> ##[1:4] (command_status[3] || error_flags[2]))
        else $error("disable gave no data request");
    prepare_no_data_a: assert property (cmd_wr && command_code == 8'hf3 |=> (!command_status[3] && !data_wr_stb)[*4])
        else $error("prepare opened a data phase");
    erase_order_a: assert property (cmd_wr && command_code == 8'hf4 && last_cmd != 8'hf3
        |-> ##[1:300] (error_flags[2] && command_status[0] && !command_status[7]))
        else $error("erase without prepare not aborted");
    sector_words_a: assert property ($fell(command_status[3]) |-> word_cnt == 9'h100)
        else $error("sector length wrong");
    strobe_in_drq_a: assert property (data_wr_stb |-> command_status[3])
        else $error("data word outside data request");
    drq_not_busy_a: assert property (command_status[3] |-> !command_status[7])
        else $error("data request while busy");
endmodule : dsr_properties

// ### tb/dsr_tb.sv
`timescale 1ns/1ps
`include "dsr_defines.svh"
module dsr_tb
    import dsr_pkg::*;
;
    logic        sys_clk = 1'b0, sys_rst = 1'b1, go = 1'b0, sel = 1'b0, frozen = 1'b0;
    logic        seek_done = 1'b0, seek_fail = 1'b0, servo_bad = 1'b0, wipe_ack = 1'b0, wipe_ok = 1'b1;
    logic [7:0]  cmd = 8'h00, lst, lerr;
    logic [15:0] pw_fill = 16'h0000, pw_word, id_data;
    logic [8:0]  pw_index, id_addr = 9'h000;
    logic [3:0]  seek_cnt = 4'h0;
    logic [27:0] last_blk = 28'h00f, wipe_n = 28'h0, wipe_lba;
    logic        seek_start, wipe_we, lock_en, done;
    int          mismatches = 0;
    int          check_count = 0;
    always #2 sys_clk = ~sys_clk;
    dsr_if tf ();
    dsr_device dsr_device_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1), .tf(tf.dev), .frozen(frozen),
        .seek_done(seek_done), .seek_fail(seek_fail), .physical_last_block(last_blk), .wipe_ack(wipe_ack),
        .id_word_addr(id_addr), .seek_start(seek_start), .wipe_we(wipe_we), .wipe_lba(wipe_lba),
        .lock_enabled(lock_en), .id_word_data(id_data));
    dsr_host dsr_host_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1), .tf(tf.host), .go(go), .cmd(cmd),
        .sel_master(sel), .pw_word(pw_word), .pw_index(pw_index), .busy(), .done(done), .last_status(lst),
        .last_error(lerr));
    dsr_properties dsr_properties_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .command_code(tf.command_code),
        .cmd_wr(tf.cmd_wr), .drive_head_select(tf.drive_head_select), .data_wr(tf.data_wr),
        .data_wr_stb(tf.data_wr_stb), .command_status(tf.command_status), .error_flags(tf.error_flags));
    assign pw_word = (pw_index == 9'h000) ? {15'h0, sel} : pw_fill;
    // servo answers a few cycles after the head-return request
    always @(posedge sys_clk)
    begin
        seek_done <= 1'b0;
        seek_fail <= 1'b0;
        if (seek_start)
            seek_cnt <= 4'h5;
        else if (seek_cnt != 4'h0)
        begin
            seek_cnt <= seek_cnt - 4'h1;
            seek_done <= (seek_cnt == 4'h1) && !servo_bad;
            seek_fail <= (seek_cnt == 4'h1) && servo_bad;
        end
    end
    // media stalls every other write, so the erase must hold each block
    always @(posedge sys_clk)
    begin
        wipe_ack <= wipe_we & ~wipe_ack;
        if (wipe_we && wipe_ack)
        begin
            if (wipe_lba !== wipe_n)
                wipe_ok <= 1'b0;
            wipe_n <= wipe_n + 28'h1;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic run(input logic [7:0] c, input logic s, input logic [15:0] fill);
        int n;
        @(posedge sys_clk);
        cmd <= c;
        sel <= s;
        pw_fill <= fill;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        for (n = 0; n < 3000 && done !== 1'b1; n++)
            @(negedge sys_clk);
        // return on a rising edge so callers change inputs there
        @(posedge sys_clk);
        check(n < 3000, 1);
    endtask : run
    task automatic t_recal;
        run(8'h10, 1'b0, 16'h0);
        check({lerr, lst}, 16'h0050);
        servo_bad <= 1'b1;
        run(8'h1f, 1'b0, 16'h0);
        check({lerr, lst}, 16'h0251);
        servo_bad <= 1'b0;
    endtask : t_recal
    task automatic t_disable;
        run(8'hf6, 1'b0, 16'h0);
        check({lerr, lst}, 16'h0050);
        run(8'hf6, 1'b0, 16'h1234);
        check({lerr, lst}, 16'h0451);
        run(8'hf6, 1'b1, 16'h0);
        check({lerr, lst}, 16'h0050);
        check(lock_en, 1'b0);
    endtask : t_disable
    task automatic t_erase;
        run(8'hf4, 1'b0, 16'h0);
        check({lerr, lst}, 16'h0451);
        run(8'hf3, 1'b0, 16'h0);
        check({lerr, lst}, 16'h0050);
        run(8'h10, 1'b0, 16'h0);
        run(8'hf4, 1'b0, 16'h0);
        check({lerr, lst}, 16'h0451);
        run(8'hf3, 1'b0, 16'h0);
        wipe_n <= 28'h0;
        run(8'hf4, 1'b1, 16'h5555);
        check({lerr, lst}, 16'h0050);
        check(wipe_n, last_blk + 28'h1);
        check(wipe_ok, 1'b1);
        check(lock_en, 1'b0);
    endtask : t_erase
    task automatic t_frozen;
        frozen <= 1'b1;
        run(8'hf3, 1'b0, 16'h0);
        run(8'hf4, 1'b0, 16'h0);
        check({lerr, lst}, 16'h0451);
        run(8'hf6, 1'b0, 16'h0);
        check({lerr, lst}, 16'h0451);
        run(8'h50, 1'b0, 16'h0);
        check({lerr, lst}, 16'h0451);
        frozen <= 1'b0;
    endtask : t_frozen
    task automatic t_ident;
        @(posedge sys_clk);
        id_addr <= {1'b0, `DSR_ID_ERASE_WORD};
        repeat (3) @(posedge sys_clk);
        check(id_data, `DSR_ERASE_MINUTES);
    endtask : t_ident
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    initial
    begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_recal();
        t_disable();
        t_erase();
        t_frozen();
        t_ident();
        complete_run();
    end
    // whole sequence needs well under two thousand cycles
    initial
    begin
        #80000;
        mismatches++;
        complete_run();
    end
endmodule : dsr_tb
